// file: rtl/sda_audio_in.sv
// Audio serial input, system clock output and initialization of the six-channel front end.
`include "sda_consts.svh"

// Summary of operation
// - Buffered clock output copies system clock at full or half rate.
// - Buffered clock output is enabled or disabled; enabled after reset.
// - After power-on, 1024 system clocks of initialization on mode defaults, then the control inputs.
// - Rising external reset starts 1024 system clock initialization on defaults, then the control inputs.
// - Each data line is shifted in on every bit clock rising edge.
// - Word clock edges move completed samples into the sample registers.
// - Format select picks standard, I2S or left-justified; default 24-bit standard.
// - Samples are two's complement, most significant bit first.
// - Left sample precedes right sample in every frame.
// - Line 1 feeds outputs 1 and 2, line 2 outputs 3 and 4, line 3 outputs 5 and 6.
// - Word clock high means left in standard and left-justified, low in I2S.
// - Standard format accepts right-justified 16, 18, 20 or 24-bit words.
module sda_audio_in (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic systemClockIn,
  input wire logic externalReset_n,
  input wire logic audioBitClock,
  input wire logic audioWordClock,
  input wire logic serialAudioLine1,
  input wire logic serialAudioLine2,
  input wire logic serialAudioLine3,
  input wire logic [2:0] formatSelect,
  input wire logic clockOutDivide,
  input wire logic clockOutEnable,
  output sda_pkg::sda_frame_s frameData,
  output logic frameValid,
  input wire logic frameReady,
  output logic frameOverrun,
  output logic bufferedClockOut,
  output logic initBusy
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Every pin here comes from outside core_clk, so all of them pass two flip-flops.
  logic [6:0] pinRaw;
  logic [6:0] pinMeta;
  logic [6:0] pinSync;
  logic [6:0] pinPrev;
  assign pinRaw = {serialAudioLine3, serialAudioLine2, serialAudioLine1,
                   audioWordClock, audioBitClock, externalReset_n, systemClockIn};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinMeta <= 7'h00;
      pinSync <= 7'h00;
      pinPrev <= 7'h00;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  logic sysClkRise;
  logic extRstRise;
  logic bitClkRise;
  logic wordLevel;
  assign sysClkRise = pinSync[0] & ~pinPrev[0];
  assign extRstRise = pinSync[1] & ~pinPrev[1];
  assign bitClkRise = pinSync[2] & ~pinPrev[2];
  assign wordLevel = pinSync[3];

  // ****************************************
  // Initialization sequence
  // ****************************************
  sda_pkg::sda_init_e initState;
  sda_pkg::sda_init_e next_initState;
  logic [10:0] initCount;
  logic [10:0] next_initCount;
  sda_pkg::sda_mode_s mode;
  sda_pkg::sda_mode_s next_mode;

  always_comb begin
    next_initState = initState;
    next_initCount = initCount;
    next_mode = mode;
    unique case (initState)
      sda_pkg::INIT_HOLD: begin
        next_initCount = 11'h000;
        if (extRstRise) begin
          next_initState = sda_pkg::INIT_COUNT;
        end
      end
      sda_pkg::INIT_COUNT: begin
        if (sysClkRise) begin
          next_initCount = initCount + 11'h001;
        end
        if (initCount == `SDA_INIT_SYSCLKS) begin
          next_initState = sda_pkg::INIT_DONE;
        end
      end
      sda_pkg::INIT_DONE: begin
        next_mode.formatSelect = formatSelect;
        next_mode.clockOutDivide = clockOutDivide;
        next_mode.clockOutEnable = clockOutEnable;
      end
      default: begin
        next_initState = sda_pkg::INIT_HOLD;
      end
    endcase
    // A low external reset aborts the sequence and holds the defaults.
    if (!pinSync[1]) begin
      next_initState = sda_pkg::INIT_HOLD;
    end
    if (next_initState != sda_pkg::INIT_DONE) begin
      next_mode.formatSelect = `SDA_RST_FORMAT;
      next_mode.clockOutDivide = `SDA_RST_CLK_DIVIDE;
      next_mode.clockOutEnable = `SDA_RST_CLK_ENABLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      initState <= sda_pkg::INIT_COUNT;
      initCount <= 11'h000;
      mode <= '{`SDA_RST_FORMAT, `SDA_RST_CLK_DIVIDE, `SDA_RST_CLK_ENABLE};
      initBusy <= 1'b1;
    end else begin
      initState <= next_initState;
      initCount <= next_initCount;
      mode <= next_mode;
      initBusy <= (next_initState != sda_pkg::INIT_DONE);
    end
  end

  // ****************************************
  // Buffered clock output
  // ****************************************
  // The copy is rebuilt from the sampled clock, so it lags the pin by a few core cycles.
  logic halfClk;
  logic next_halfClk;
  logic next_bufferedClockOut;

  always_comb begin
    next_halfClk = halfClk ^ sysClkRise;
    if (!mode.clockOutEnable) begin
      next_bufferedClockOut = 1'b0;
    end else if (mode.clockOutDivide) begin
      next_bufferedClockOut = halfClk;
    end else begin
      next_bufferedClockOut = pinSync[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      halfClk <= 1'b0;
      bufferedClockOut <= 1'b0;
    end else begin
      halfClk <= next_halfClk;
      bufferedClockOut <= next_bufferedClockOut;
    end
  end

  // ****************************************
  // Serial word framing
  // ****************************************
  function automatic logic isLeft(input logic [2:0] fmt, input logic level);
    isLeft = (fmt == `SDA_FMT_I2S) ? ~level : level;
  endfunction

  function automatic logic [23:0] alignRight(input logic [2:0] fmt, input logic [23:0] bits);
    unique case (fmt)
      `SDA_FMT_STD20: alignRight = {bits[19:0], 4'h0};
      `SDA_FMT_STD18: alignRight = {bits[17:0], 6'h00};
      `SDA_FMT_STD16: alignRight = {bits[15:0], 8'h00};
      default: alignRight = bits;
    endcase
  endfunction

  logic lastWord;
  logic next_lastWord;
  logic [4:0] bitIndex;
  logic [4:0] next_bitIndex;
  logic [4:0] justCount;
  logic [4:0] next_justCount;
  logic wordEdge;
  logic justified;
  logic [4:0] justStart;
  logic justShift;

  assign wordEdge = bitClkRise && (wordLevel != lastWord);
  assign justified = (mode.formatSelect == `SDA_FMT_I2S) || (mode.formatSelect == `SDA_FMT_LJ);
  assign justStart = (mode.formatSelect == `SDA_FMT_I2S) ? 5'h01 : 5'h00;

  always_comb begin
    next_lastWord = lastWord;
    next_bitIndex = bitIndex;
    next_justCount = justCount;
    justShift = 1'b0;
    if (bitClkRise) begin
      next_lastWord = wordLevel;
      next_bitIndex = wordEdge ? 5'h00 : ((bitIndex == 5'h1F) ? bitIndex : bitIndex + 5'h01);
      justShift = (next_bitIndex >= justStart) && (justCount < 5'd24 || wordEdge);
      if (wordEdge) begin
        next_justCount = justShift ? 5'h01 : 5'h00;
      end else if (justShift) begin
        next_justCount = justCount + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lastWord <= 1'b0;
      bitIndex <= 5'h00;
      justCount <= 5'h00;
    end else begin
      lastWord <= next_lastWord;
      bitIndex <= next_bitIndex;
      justCount <= next_justCount;
    end
  end

  // ****************************************
  // Per-line shift and sample registers
  // ****************************************
  logic [2:0][23:0] leftHold;
  logic [2:0][23:0] wordDone;
  logic [2:0][23:0] freeShift;
  logic [2:0][23:0] justShiftReg;

  for (genvar ln = 0; ln < 3; ln++) begin : g_line
    logic [23:0] next_free;
    logic [23:0] next_just;
    logic [23:0] next_left;
    always_comb begin
      next_free = freeShift[ln];
      next_just = justShiftReg[ln];
      next_left = leftHold[ln];
      // Short justified words are padded low so the MSB stays at bit 23.
      if (justified) begin
        wordDone[ln] = justShiftReg[ln] << (5'd24 - justCount);
      end else begin
        wordDone[ln] = alignRight(mode.formatSelect, freeShift[ln]);
      end
      if (wordEdge && isLeft(mode.formatSelect, lastWord)) begin
        next_left = wordDone[ln];
      end
      if (bitClkRise) begin
        next_free = {freeShift[ln][22:0], pinSync[4 + ln]};
        if (wordEdge) begin
          next_just = {23'h000000, pinSync[4 + ln] & justShift};
        end else if (justShift) begin
          next_just = {justShiftReg[ln][22:0], pinSync[4 + ln]};
        end
      end
    end
    always_ff @(posedge core_clk) begin
      if (rst) begin
        freeShift[ln] <= 24'h000000;
        justShiftReg[ln] <= 24'h000000;
        leftHold[ln] <= 24'h000000;
      end else begin
        freeShift[ln] <= next_free;
        justShiftReg[ln] <= next_just;
        leftHold[ln] <= next_left;
      end
    end
  end

  // ****************************************
  // Two-entry frame buffer
  // ****************************************
  // The serial source cannot be stalled, so a frame that meets a full buffer is
  // dropped and flagged rather than overwriting one the receiver has not taken.
  sda_pkg::sda_frame_s newFrame;
  sda_pkg::sda_frame_s spare;
  sda_pkg::sda_frame_s next_frameData;
  sda_pkg::sda_frame_s next_spare;
  logic spareValid;
  logic next_spareValid;
  logic next_frameValid;
  logic next_frameOverrun;
  logic pushFrame;
  logic popFrame;
  logic bufferReady;

  always_comb begin
    for (int ln = 0; ln < 3; ln++) begin
      newFrame.sample[2 * ln] = leftHold[ln];
      newFrame.sample[2 * ln + 1] = wordDone[ln];
    end
  end

  assign bufferReady = !spareValid;
  // A frame closes when its right word ends, after its left word.
  assign pushFrame = wordEdge && !isLeft(mode.formatSelect, lastWord) && !initBusy;
  assign popFrame = frameValid && frameReady;

  always_comb begin
    next_frameData = frameData;
    next_spare = spare;
    next_frameValid = frameValid;
    next_spareValid = spareValid;
    next_frameOverrun = pushFrame && !bufferReady;
    if (popFrame) begin
      next_frameValid = spareValid;
      next_frameData = spare;
      next_spareValid = 1'b0;
    end
    if (pushFrame && bufferReady) begin
      if (!next_frameValid) begin
        next_frameValid = 1'b1;
        next_frameData = newFrame;
      end else begin
        next_spareValid = 1'b1;
        next_spare = newFrame;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      frameData <= '0;
      spare <= '0;
      frameValid <= 1'b0;
      spareValid <= 1'b0;
      frameOverrun <= 1'b0;
    end else begin
      frameData <= next_frameData;
      spare <= next_spare;
      frameValid <= next_frameValid;
      spareValid <= next_spareValid;
      frameOverrun <= next_frameOverrun;
    end
  end

endmodule

// file: rtl/sda_consts.svh
// Constant definitions for the six-channel audio input front end.
`ifndef SDA_CONSTS_SVH
`define SDA_CONSTS_SVH
`define SDA_INIT_SYSCLKS 11'h400
`define SDA_SAMPLE_BITS 24
`define SDA_FMT_STD24 3'h0
`define SDA_FMT_STD20 3'h1
`define SDA_FMT_STD18 3'h2
`define SDA_FMT_STD16 3'h3
`define SDA_FMT_I2S 3'h4
`define SDA_FMT_LJ 3'h5
`define SDA_RST_FORMAT 3'h0
`define SDA_RST_CLK_DIVIDE 1'h0
`define SDA_RST_CLK_ENABLE 1'h1
`endif

// file: rtl/sda_pkg.sv
// Types shared by the six-channel audio input front end.
package sda_pkg;
  typedef enum logic [1:0] {
    INIT_HOLD = 2'b00,
    INIT_COUNT = 2'b01,
    INIT_DONE = 2'b10
  } sda_init_e;

  typedef struct packed {
    logic [2:0] formatSelect;
    logic clockOutDivide;
    logic clockOutEnable;
  } sda_mode_s;

  // Element 0 is output 1 (line 1 left) through element 5, output 6 (line 3 right).
  typedef struct packed {
    logic [5:0][23:0] sample;
  } sda_frame_s;
endpackage

// file: verif/sda_audio_in_assertions.sv
// Checker of the audio input front end port behaviour.
`include "sda_consts.svh"
module sda_audio_in_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic systemClockIn,
  input wire logic externalReset_n,
  input wire logic clockOutDivide,
  input wire logic clockOutEnable,
  input wire sda_pkg::sda_frame_s frameData,
  input wire logic frameValid,
  input wire logic frameReady,
  input wire logic frameOverrun,
  input wire logic bufferedClockOut,
  input wire logic initBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Raw pin rises are counted, so the bound allows one rise below and two above for sync skew.
  logic [11:0] rises, next_rises;
  logic sysPrev;
  always_comb begin
    next_rises = rises;
    if (rst || !externalReset_n)
      next_rises = 12'h0;
    else if (initBusy && systemClockIn && !sysPrev)
      next_rises = rises + 12'h1;
  end
  always_ff @(posedge core_clk) begin
    rises <= next_rises;
    sysPrev <= systemClockIn;
  end
  a_init_len: assert property ($fell(initBusy) |->
    rises >= `SDA_INIT_SYSCLKS - 1 && rises <= `SDA_INIT_SYSCLKS + 2) else $error("init length");
  a_full_rate: assert property (
    (clockOutEnable && !clockOutDivide && !initBusy)[*8]
    |-> bufferedClockOut != $past(bufferedClockOut, 2)) else $error("full rate clock");
  a_half_rate: assert property (
    (clockOutEnable && clockOutDivide && !initBusy)[*8]
    |-> bufferedClockOut != $past(bufferedClockOut, 4)) else $error("half rate clock");
  a_clock_off: assert property (
    (!clockOutEnable && !initBusy)[*3] |-> !bufferedClockOut) else $error("clock not off");
  a_init_default: assert property (
    initBusy[*8] |-> bufferedClockOut != $past(bufferedClockOut, 2)) else $error("init clock");
  a_ext_busy: assert property (
    !externalReset_n[*4] |-> initBusy) else $error("busy in reset");
  a_frame_hold: assert property (
    frameValid && !frameReady |=> frameValid && $stable(frameData)) else $error("frame hold");
  a_overrun_pulse: assert property (
    frameOverrun |-> frameValid ##1 !frameOverrun) else $error("overrun pulse");
  a_reset_state: assert property (disable iff (1'b0)
    rst |=> initBusy && !frameValid && !frameOverrun && !bufferedClockOut) else $error("reset");
endmodule

bind sda_audio_in sda_audio_in_assertions u_chk (.*);

// file: verif/sda_audio_src.sv
// Behavioural audio source driving both audio clocks and three data lines.
module sda_audio_src (
  input wire logic [2:0] fmt,
  output logic audio_bit_clock,
  output logic wck,
  output logic [2:0] sd
);
  timeunit 1ns;
  timeprecision 1ps;
  sda_pkg::sda_frame_s cur;
  initial begin
    audio_bit_clock = 1'b0;
    wck = 1'b0;
    sd = 3'h0;
  end
  // Unused slots carry random bits, so a misaligned capture shows up.
  task automatic slot(input int h, input int i);
    int n, p;
    logic [23:0] w;
    n = fmt == 3'h1 ? 20 : fmt == 3'h2 ? 18 : fmt == 3'h3 ? 16 : 24;
    p = fmt == 3'h5 ? i : fmt == 3'h4 ? i - 1 : i - 32 + n;
    wck = (h == 0) ^ (fmt == 3'h4);
    for (int l = 0; l < 3; l++) begin
      w = cur.sample[2 * l + h];
      sd[l] = (p >= 0 && p < n) ? w[23 - p] : 1'($urandom);
    end
    #16 audio_bit_clock = 1'b1;
    #32 audio_bit_clock = 1'b0;
    #16;
  endtask
  task automatic send_frame(input sda_pkg::sda_frame_s s);
    cur = s;
    for (int k = 0; k < 64; k++)
      slot(k / 32, k % 32);
  endtask
  task automatic prime;
    slot(1, 31);
  endtask
  task automatic flush;
    slot(0, 0);
  endtask
endmodule

// file: verif/tb_sda_audio_in.sv
// Self-checking testbench of the six-channel audio input front end.
module tb_sda_audio_in;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst = 1'b1, systemClockIn = 1'b0, externalReset_n = 1'b1;
  logic clockOutDivide = 1'b0, clockOutEnable = 1'b1, frameReady = 1'b0, randReady = 1'b0;
  logic [2:0] formatSelect = 3'h0;
  logic audioBitClock, audioWordClock, serialAudioLine1, serialAudioLine2, serialAudioLine3;
  logic frameValid, frameOverrun, bufferedClockOut, initBusy;
  sda_pkg::sda_frame_s frameData, s;
  sda_pkg::sda_frame_s got[$], want[$];
  int n_fail = 0, total_checks = 0, ovr = 0, sysRises = 0, outRises = 0, k, n, m0;
  always #2 core_clk = ~core_clk;
  // The system clock is 256 times the frame rate of the 64 ns bit clock.
  always #8 systemClockIn = ~systemClockIn;
  always @(posedge systemClockIn) sysRises++;
  always @(posedge bufferedClockOut) outRises++;
  always @(negedge core_clk) frameReady <= randReady & 1'($urandom);
  always @(posedge core_clk) begin
    if (frameValid === 1'b1 && frameReady === 1'b1)
      got.push_back(frameData);
    if (frameOverrun === 1'b1)
      ovr++;
  end
  sda_audio_src src (.fmt(formatSelect), .audio_bit_clock(audioBitClock), .wck(audioWordClock),
    .sd({serialAudioLine3, serialAudioLine2, serialAudioLine1}));
  sda_audio_in dut (.*);
  function automatic sda_pkg::sda_frame_s ideal(input sda_pkg::sda_frame_s v, input int f);
    logic [23:0] mask;
    mask = f == 1 ? 24'hFFFFF0 : f == 2 ? 24'hFFFFC0 : f == 3 ? 24'hFFFF00 : 24'hFFFFFF;
    for (int c = 0; c < 6; c++)
      ideal.sample[c] = v.sample[c] & mask;
  endfunction
  task automatic chk(input string what, input logic [143:0] seen, input logic [143:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wait_idle;
    n = 0;
    while (initBusy !== 1'b0) begin
      @(negedge core_clk);
      if (++n > 9000) begin
        n_fail++;
        wrap_up();
      end
    end
    chk("init length", sysRises - k >= 1023 && sysRises - k <= 1027, 1'b1);
  endtask
  task automatic count_out(input int e);
    m0 = outRises;
    repeat (200) @(negedge core_clk);
    chk("clock out", outRises - m0 >= e - 1 && outRises - m0 <= e + 1, 1'b1);
  endtask
  initial begin
    void'($urandom(32'h93FB4ADB));
    repeat (3) @(negedge core_clk);
    k = sysRises;
    rst = 1'b0;
    wait_idle();
    // ****************************************
    // Reset pulse of 20 ns with both clock controls off their defaults.
    // ****************************************
    clockOutEnable = 1'b0;
    clockOutDivide = 1'b1;
    externalReset_n = 1'b0;
    repeat (5) @(negedge core_clk);
    chk("busy", initBusy, 1'b1);
    k = sysRises;
    externalReset_n = 1'b1;
    count_out(50);
    wait_idle();
    for (int m = 0; m < 4; m++) begin
      clockOutEnable = m[1];
      clockOutDivide = m[0];
      repeat (8) @(negedge core_clk);
      count_out(m[1] ? (m[0] ? 25 : 50) : 0);
    end
    // ****************************************
    // Every format code, then a stalled receiver.
    // ****************************************
    randReady = 1'b1;
    for (int f = 0; f < 9; f++) begin
      formatSelect = f[2:0];
      randReady = f != 8;
      n = got.size();
      ovr = 0;
      repeat (4) @(negedge core_clk);
      src.prime();
      for (int j = 0; j < 4; j++) begin
        for (int c = 0; c < 6; c++)
          s.sample[c] = 24'($urandom);
        want.push_back(ideal(s, f % 8));
        src.send_frame(s);
      end
      src.flush();
      repeat (40) @(negedge core_clk);
      if (f == 8) begin
        chk("overruns", ovr >= 2, 1'b1);
        randReady = 1'b1;
        repeat (40) @(negedge core_clk);
        chk("frames kept", got.size() - n, 144'h2);
      end else begin
        for (int j = 0; j < 4; j++)
          chk("frame", got[got.size() - 4 + j], want[j]);
      end
      want.delete();
    end
    wrap_up();
  end
endmodule
